// ---- fabric_ctl.sv ----
// Fabric-side model that makes the output register enables
`timescale 1ns/1ps
module fabric_ctl (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_hold,
  input wire logic [1:0] i_slow,
  output logic [1:0] o_out_ce
);
  logic [1:0] phase_reg;
  // =====================================================
  // Output enable generation
  // Enables move on the falling edge so the block samples them settled
  // fabric drives enables
  always @(negedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  assign o_out_ce = ~i_hold & (~i_slow | phase_reg);
endmodule

// ---- memblk_params.svh ----
// Depth, CAM sizes, field positions, reset values and cycle counts of the memory block
`ifndef MEMBLK_PARAMS_SVH
`define MEMBLK_PARAMS_SVH

// =====================================================
// Depth and CAM geometry
`define MEM_BLOCK_DEPTH 4096
`define CAM_WORDS 32
`define CAM_OUTS 16
`define CAM_ENC_W 5

// =====================================================
// CAM write timing in cycles
`define CAM_WR_CYCLES 2
`define CAM_WR_DC_CYCLES 3

// =====================================================
// Bit positions in the pipeline select mask
`define PIPE_WDATA 0
`define PIPE_RDATA 1
`define PIPE_RADDR 2
`define PIPE_WADDR 3
`define PIPE_WE 4
`define PIPE_RE 5
`define PIPE_SEL_RESET 6'h00

// =====================================================
// Reset values
`define RESET_DATA 1'b0

`endif

// ---- memblk_pkg.sv ----
// Types shared by the memory block modules
package memblk_pkg;
  // =====================================================
  // CAM sequencer states and lookup modes
  typedef enum logic [1:0] {
    CAM_IDLE = 2'b00,
    CAM_WR = 2'b01,
    CAM_RD_HI = 2'b10
  } cam_state_type;

  typedef enum logic {
    MODE_MULTI = 1'b0,
    MODE_FAST = 1'b1
  } cam_mode_type;
endpackage

// ---- memblk_top.sv ----
// Dual-port RAM with per-port input/output enables and a 32-word CAM
`timescale 1ns/1ps
module memblk_top
  import memblk_pkg::*;
#(
  parameter int W = 16,
  parameter int BLOCKS = 1,
  parameter int AW = 12,
  parameter int CW = 8,
  parameter logic [5:0] PIPE_SEL = 6'h00,
  parameter logic [32*CW-1:0] CAM_INIT_DATA = '0,
  parameter logic [32*CW-1:0] CAM_INIT_CARE = '0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_a_in_ce,
  input wire logic i_a_out_ce,
  input wire logic i_a_wr_ce,
  input wire logic i_a_rd_ce,
  input wire logic i_a_clr,
  input wire logic i_a_write_strobe,
  input wire logic i_a_read_strobe_in,
  input wire logic [AW-1:0] i_a_waddr,
  input wire logic [AW-1:0] i_a_raddr,
  input wire logic [W-1:0] i_a_wdata,
  output logic [W-1:0] o_a_rdata,
  output logic o_a_rvalid,
  input wire logic i_b_in_ce,
  input wire logic i_b_out_ce,
  input wire logic i_b_wr_ce,
  input wire logic i_b_rd_ce,
  input wire logic i_b_clr,
  input wire logic i_b_write_strobe,
  input wire logic i_b_read_strobe_in,
  input wire logic [AW-1:0] i_b_waddr,
  input wire logic [AW-1:0] i_b_raddr,
  input wire logic [W-1:0] i_b_wdata,
  output logic [W-1:0] o_b_rdata,
  output logic o_b_rvalid,
  input wire logic i_cam_mode,
  input wire logic i_cam_write,
  input wire logic i_cam_dc,
  input wire logic [4:0] i_cam_waddr,
  input wire logic [CW-1:0] i_cam_wdata,
  input wire logic [CW-1:0] i_cam_wcare,
  input wire logic i_cam_look,
  input wire logic [CW-1:0] i_cam_key,
  output logic o_cam_busy,
  output logic [15:0] o_match_vec,
  output logic [4:0] o_match_addr,
  output logic o_match_found,
  output logic o_match_valid,
  output logic o_match_half
);
`include "memblk_params.svh"

  localparam int DEPTH = BLOCKS * `MEM_BLOCK_DEPTH;

  typedef struct packed {
    logic [1:0] we_q;
    logic [1:0] re_q;
    logic [1:0][AW-1:0] wa_q;
    logic [1:0][AW-1:0] ra_q;
    logic [1:0][W-1:0] wd_q;
    logic [1:0][W-1:0] rd_q;
    logic [1:0] rv_q;
    cam_state_type cst;
    logic [1:0] wcnt;
    logic [CW-1:0] key;
    logic [4:0] wa;
    logic [CW-1:0] wd;
    logic [CW-1:0] wc;
    logic dc;
    logic [31:0][CW-1:0] cdata;
    logic [31:0][CW-1:0] ccare;
    logic busy;
    logic [15:0] mvec;
    logic [4:0] maddr;
    logic found;
    logic mvalid;
    logic mhalf;
  } state_type;

  state_type s_reg;
  state_type s_next;
  logic [W-1:0] mem [DEPTH];

  // =====================================================
  // Port gathering
  logic [1:0] in_ce, out_ce, wr_ce, rd_ce, clr, we_in, re_in;
  logic [1:0][AW-1:0] wa_in, ra_in, wa_e, ra_e;
  logic [1:0][W-1:0] wd_in, wd_e;
  logic [1:0] we_e, re_e, wr_fire, rd_fire;
  logic [1:0][W-1:0] rdata_o;
  logic [1:0] rvalid_o;

  // two enables per port stand in for the two clocks
  assign in_ce = {i_b_in_ce, i_a_in_ce};
  assign out_ce = {i_b_out_ce, i_a_out_ce};
  assign wr_ce = {i_b_wr_ce, i_a_wr_ce};
  assign rd_ce = {i_b_rd_ce, i_a_rd_ce};
  assign clr = {i_b_clr, i_a_clr};
  // strobes come straight from user logic
  assign we_in = {i_b_write_strobe, i_a_write_strobe};
  assign re_in = {i_b_read_strobe_in, i_a_read_strobe_in};
  assign wa_in = {i_b_waddr, i_a_waddr};
  assign ra_in = {i_b_raddr, i_a_raddr};
  assign wd_in = {i_b_wdata, i_a_wdata};

  // =====================================================
  // Per-port input selection and output stage
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      // each input picks registered or direct
      assign we_e[p] = PIPE_SEL[`PIPE_WE] ? s_reg.we_q[p] : we_in[p];
      assign re_e[p] = PIPE_SEL[`PIPE_RE] ? s_reg.re_q[p] : re_in[p];
      assign wa_e[p] = PIPE_SEL[`PIPE_WADDR] ? s_reg.wa_q[p] : wa_in[p];
      assign ra_e[p] = PIPE_SEL[`PIPE_RADDR] ? s_reg.ra_q[p] : ra_in[p];
      assign wd_e[p] = PIPE_SEL[`PIPE_WDATA] ? s_reg.wd_q[p] : wd_in[p];
      assign wr_fire[p] = in_ce[p] & wr_ce[p] & we_e[p];
      assign rd_fire[p] = in_ce[p] & rd_ce[p] & re_e[p];

      rd_out_if #(.W(W)) oif ();
      assign oif.data = s_reg.rd_q[p];
      assign oif.valid = s_reg.rv_q[p];
      assign oif.out_ce = out_ce[p];
      // each port has its own clear
      assign oif.clr = clr[p];

      port_out_stage #(.W(W), .EXTRA(PIPE_SEL[`PIPE_RDATA])) u_out (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .bus(oif.dst),
        .o_data(rdata_o[p]),
        .o_valid(rvalid_o[p])
      );
    end
  endgenerate

  assign o_a_rdata = rdata_o[0];
  assign o_a_rvalid = rvalid_o[0];
  assign o_b_rdata = rdata_o[1];
  assign o_b_rvalid = rvalid_o[1];

  // =====================================================
  // Storage array
  // each block adds depth; width is a parameter
  // upper address bits pick the block, lower the word
  // Port B is written last, so it wins a same-address collision
  always_ff @(posedge i_clk) begin
    for (int q = 0; q < 2; q++) begin
      if (wr_fire[q] && (int'(wa_e[q]) < DEPTH)) begin
        mem[wa_e[q]] <= wd_e[q];
      end
    end
  end

  // =====================================================
  // CAM match lines
  logic [CW-1:0] key_cmp;
  logic [31:0] hit;
  assign key_cmp = (s_reg.cst == CAM_IDLE) ? i_cam_key : s_reg.key;

  genvar g;
  generate
    for (g = 0; g < `CAM_WORDS; g++) begin : g_cam
      // Care bit set means the stored bit is ignored
      assign hit[g] = ((s_reg.cdata[g] ^ key_cmp) & ~s_reg.ccare[g]) == '0;
    end
  endgenerate

  // lowest matching word wins the encoded address
  function automatic logic [4:0] enc16(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // =====================================================
  // Next state
  logic [4:0] enc;
  logic [1:0] wr_last;
  always_comb begin
    s_next = s_reg;
    enc = 5'h00;
    wr_last = s_reg.dc ? 2'(`CAM_WR_DC_CYCLES - 1) : 2'(`CAM_WR_CYCLES - 1);
    s_next.mvalid = 1'b0;
    // one input enable loads all input-side registers
    for (int q = 0; q < 2; q++) begin
      s_next.rv_q[q] = 1'b0;
      if (in_ce[q]) begin
        s_next.we_q[q] = we_in[q];
        s_next.re_q[q] = re_in[q];
        s_next.wa_q[q] = wa_in[q];
        s_next.ra_q[q] = ra_in[q];
        s_next.wd_q[q] = wd_in[q];
      end
      if (rd_fire[q]) begin
        s_next.rd_q[q] = (int'(ra_e[q]) < DEPTH) ? mem[ra_e[q]] : '0;
        s_next.rv_q[q] = 1'b1;
      end
    end
    case (s_reg.cst)
      CAM_IDLE: begin
        if (i_cam_write) begin
          s_next.wa = (i_cam_mode == MODE_FAST) ? {1'b0, i_cam_waddr[3:0]} : i_cam_waddr;
          s_next.wd = i_cam_wdata;
          s_next.wc = i_cam_dc ? i_cam_wcare : '0;
          s_next.dc = i_cam_dc;
          s_next.wcnt = 2'h1;
          s_next.busy = 1'b1;
          s_next.cst = CAM_WR;
        end else if (i_cam_look) begin
          // fast mode answers from 16 words next cycle
          enc = enc16(hit[15:0]);
          s_next.mvec = hit[15:0];
          s_next.maddr = {1'b0, enc[3:0]};
          s_next.found = enc[4];
          s_next.mvalid = 1'b1;
          s_next.mhalf = 1'b0;
          s_next.key = i_cam_key;
          if (i_cam_mode == MODE_MULTI) begin
            s_next.busy = 1'b1;
            s_next.cst = CAM_RD_HI;
          end
        end
      end
      CAM_WR: begin
        // word stored on the last write cycle
        if (s_reg.wcnt >= wr_last) begin
          s_next.cdata[s_reg.wa] = s_reg.wd;
          s_next.ccare[s_reg.wa] = s_reg.wc;
          s_next.busy = 1'b0;
          s_next.cst = CAM_IDLE;
        end else begin
          s_next.wcnt = s_reg.wcnt + 2'h1;
        end
      end
      CAM_RD_HI: begin
        // upper 16 words follow in the second cycle
        enc = enc16(hit[31:16]);
        s_next.mvec = hit[31:16];
        s_next.maddr = {1'b1, enc[3:0]};
        s_next.found = enc[4];
        s_next.mvalid = 1'b1;
        s_next.mhalf = 1'b1;
        s_next.busy = 1'b0;
        s_next.cst = CAM_IDLE;
      end
      default: begin
        s_next.busy = 1'b0;
        s_next.cst = CAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
      s_reg.cst <= CAM_IDLE;
      s_reg.cdata <= CAM_INIT_DATA;
      s_reg.ccare <= CAM_INIT_CARE;
    end else begin
      s_reg <= s_next;
    end
  end

  // no match leaves the vector zero and found low
  assign o_cam_busy = s_reg.busy;
  assign o_match_vec = s_reg.mvec;
  assign o_match_addr = s_reg.maddr;
  assign o_match_found = s_reg.found;
  assign o_match_valid = s_reg.mvalid;
  assign o_match_half = s_reg.mhalf;

  // =====================================================
  // Checks
  a_multi_write_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_reg.cst == CAM_IDLE) && i_cam_write && !i_cam_dc && (i_cam_mode == MODE_MULTI)
      |=> o_cam_busy ##1 !o_cam_busy)
    else $error("multiple-match write not two cycles");
  a_dc_write_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_reg.cst == CAM_IDLE) && i_cam_write && i_cam_dc |=> o_cam_busy[*2] ##1 !o_cam_busy)
    else $error("don't-care write not three cycles");
  a_fast_one_cycle: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_reg.cst == CAM_IDLE) && !i_cam_write && i_cam_look && (i_cam_mode == MODE_FAST)
      |=> o_match_valid && !o_match_half ##1 (!o_match_valid || $past(i_cam_look)))
    else $error("fast lookup not valid after one cycle");
  a_multi_two_halves: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (s_reg.cst == CAM_IDLE) && !i_cam_write && i_cam_look && (i_cam_mode == MODE_MULTI)
      |=> (o_match_valid && !o_match_half) ##1 (o_match_valid && o_match_half))
    else $error("multiple-match halves out of order");
  a_no_match_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_match_valid && (o_match_vec == 16'h0000) |-> !o_match_found)
    else $error("empty match flagged as found");
  a_encoder_lowest: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_match_valid && o_match_found |-> o_match_vec[o_match_addr[3:0]]
      && ((o_match_vec & ((16'h0001 << o_match_addr[3:0]) - 16'h0001)) == 16'h0000)
      && (o_match_addr[4] == o_match_half))
    else $error("encoded address not lowest match");
endmodule

// ---- port_out_stage.sv ----
// Output register stage of one memory port
`timescale 1ns/1ps
module port_out_stage
  import memblk_pkg::*;
#(
  parameter int W = 16,
  parameter bit EXTRA = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  rd_out_if.dst bus,
  output logic [W-1:0] o_data,
  output logic o_valid
);
`include "memblk_params.svh"

  typedef struct packed {
    logic [W-1:0] mid;
    logic mid_v;
    logic [W-1:0] data;
    logic valid;
  } state_type;

  state_type s_reg;
  state_type s_next;

  // =====================================================
  // Output registers
  // only out clock times these
  always_comb begin
    s_next = s_reg;
    if (bus.out_ce) begin
      s_next.mid = bus.data;
      s_next.mid_v = bus.valid;
      s_next.data = EXTRA ? s_reg.mid : bus.data;
      s_next.valid = EXTRA ? s_reg.mid_v : bus.valid;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn or posedge bus.clr) begin
    if (!i_resetn || bus.clr) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_data = s_reg.data;
  assign o_valid = s_reg.valid;

  // =====================================================
  // Checks
  a_out_hold_idle: assert property (@(posedge i_clk) disable iff (!i_resetn || bus.clr)
    !bus.out_ce ##1 !bus.clr |-> $stable(o_data))
    else $error("output data moved without output enable");
  a_clear_zero_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    bus.clr |-> (o_data == '0) && !o_valid)
    else $error("cleared port shows nonzero data");
endmodule

// ---- rd_out_if.sv ----
// Read data path from the memory core to a port output stage
`timescale 1ns/1ps
interface rd_out_if #(
  parameter int W = 16
);
  logic [W-1:0] data;
  logic valid;
  logic out_ce;
  logic clr;
  modport src (output data, output valid, output out_ce, output clr);
  modport dst (input data, input valid, input out_ce, input clr);
endinterface

// ---- tb_top.sv ----
// Self-checking bench for the memory block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import memblk_pkg::*;
  logic i_clk, i_resetn;
  logic [1:0] in_ce, wr_ce, rd_ce, clr, we, re, hold, slow, out_ce, rvalid;
  logic [11:0] waddr [2];
  logic [11:0] raddr [2];
  logic [15:0] wdata [2];
  logic [15:0] rdata [2];
  logic cam_mode, cam_write, cam_dc, cam_look, cam_busy, m_found, m_valid, m_half;
  logic [4:0] cam_waddr, m_addr;
  logic [7:0] cam_wdata, cam_wcare, cam_key;
  logic [15:0] m_vec;
  int bad_count = 0;
  int compares = 0;
  // =====================================================
  // Design and fabric model
  memblk_top i_memblk_top (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_a_in_ce(in_ce[0]), .i_a_out_ce(out_ce[0]), .i_a_wr_ce(wr_ce[0]),
    .i_a_rd_ce(rd_ce[0]), .i_a_clr(clr[0]), .i_a_write_strobe(we[0]),
    .i_a_read_strobe_in(re[0]), .i_a_waddr(waddr[0]), .i_a_raddr(raddr[0]),
    .i_a_wdata(wdata[0]), .o_a_rdata(rdata[0]), .o_a_rvalid(rvalid[0]),
    .i_b_in_ce(in_ce[1]), .i_b_out_ce(out_ce[1]), .i_b_wr_ce(wr_ce[1]),
    .i_b_rd_ce(rd_ce[1]), .i_b_clr(clr[1]), .i_b_write_strobe(we[1]),
    .i_b_read_strobe_in(re[1]), .i_b_waddr(waddr[1]), .i_b_raddr(raddr[1]),
    .i_b_wdata(wdata[1]), .o_b_rdata(rdata[1]), .o_b_rvalid(rvalid[1]),
    .i_cam_mode(cam_mode), .i_cam_write(cam_write), .i_cam_dc(cam_dc),
    .i_cam_waddr(cam_waddr), .i_cam_wdata(cam_wdata), .i_cam_wcare(cam_wcare),
    .i_cam_look(cam_look), .i_cam_key(cam_key), .o_cam_busy(cam_busy),
    .o_match_vec(m_vec), .o_match_addr(m_addr), .o_match_found(m_found),
    .o_match_valid(m_valid), .o_match_half(m_half));
  fabric_ctl i_fabric_ctl (.i_clk(i_clk), .i_resetn(i_resetn), .i_hold(hold),
    .i_slow(slow), .o_out_ce(out_ce));
  // =====================================================
  // Clock and verdict
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // =====================================================
  // RAM port tasks
  task automatic wait_rvalid(int p);
    int n;
    n = 0;
    while (rvalid[p] !== 1'b1 && n < 6) begin
      @(negedge i_clk);
      n++;
    end
    if (rvalid[p] !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic ram_read(int p, logic [11:0] a, logic [15:0] e);
    re[p] = 1'b1;
    raddr[p] = a;
    @(negedge i_clk);
    re[p] = 1'b0;
    wait_rvalid(p);
    `CHK(rdata[p], e)
    @(negedge i_clk);
    // A slow output enable holds the output one more cycle
    if (slow[p]) begin
      @(negedge i_clk);
    end
    `CHK(rvalid[p], 1'b0)
  endtask
  // Back-to-back writes at both ends of the block's depth
  task automatic t_ram_basic(int p);
    we[p] = 1'b1;
    waddr[p] = 12'h000;
    wdata[p] = 16'h1111 << p;
    @(negedge i_clk);
    waddr[p] = 12'hfff;
    wdata[p] = 16'h8001 + 16'(p);
    @(negedge i_clk);
    we[p] = 1'b0;
    ram_read(p, 12'h000, 16'h1111 << p);
    ram_read(p, 12'hfff, 16'h8001 + 16'(p));
  endtask
  // Held output enable, clear on one port, disabled read enable
  task automatic t_ram_ports();
    we = 2'b11;
    waddr[0] = 12'h005;
    waddr[1] = 12'h005;
    wdata[0] = 16'h1234;
    wdata[1] = 16'habcd;
    @(negedge i_clk);
    we = 2'b00;
    // Both ports share the array; port B wins the same-address write
    ram_read(0, 12'h005, 16'habcd);
    ram_read(1, 12'h005, 16'habcd);
    hold[0] = 1'b1;
    re[0] = 1'b1;
    raddr[0] = 12'h000;
    @(negedge i_clk);
    re[0] = 1'b0;
    repeat (3) @(negedge i_clk);
    `CHK(rdata[0], 16'habcd)
    clr[0] = 1'b1;
    #1 `CHK(rdata[0], 16'h0000)
    `CHK(rdata[1], 16'habcd)
    @(negedge i_clk);
    clr[0] = 1'b0;
    hold[0] = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK(rdata[0], 16'h2222)
    rd_ce[0] = 1'b0;
    re[0] = 1'b1;
    raddr[0] = 12'hfff;
    @(negedge i_clk);
    re[0] = 1'b0;
    repeat (3) @(negedge i_clk);
    `CHK(rvalid[0], 1'b0)
    `CHK(rdata[0], 16'h2222)
    rd_ce[0] = 1'b1;
    slow[1] = 1'b1;
    @(negedge i_clk);
    // Start the read in a cycle whose output enable is high
    if (out_ce[1] !== 1'b1) begin
      @(negedge i_clk);
    end
    ram_read(1, 12'hfff, 16'h8002);
    slow[1] = 1'b0;
  endtask
  // =====================================================
  // CAM tasks
  task automatic cam_wr(logic [4:0] a, logic [7:0] d, logic [7:0] c, logic dc, int n);
    cam_write = 1'b1;
    cam_waddr = a;
    cam_wdata = d;
    cam_wcare = c;
    cam_dc = dc;
    @(negedge i_clk);
    cam_write = 1'b0;
    repeat (n) begin
      `CHK(cam_busy, 1'b1)
      @(negedge i_clk);
    end
    `CHK(cam_busy, 1'b0)
  endtask
  task automatic cam_find(logic [7:0] k, logic multi, logic [15:0] v0, logic [4:0] a0,
                          logic [15:0] v1, logic [4:0] a1);
    cam_look = 1'b1;
    cam_key = k;
    @(negedge i_clk);
    cam_look = 1'b0;
    `CHK({m_valid, m_half, cam_busy}, {2'b10, multi})
    `CHK({m_vec, m_addr, m_found}, {v0, a0, |v0})
    if (multi) begin
      @(negedge i_clk);
      `CHK({m_valid, m_half, cam_busy}, 3'b110)
      `CHK({m_vec, m_addr, m_found}, {v1, a1, |v1})
    end
    @(negedge i_clk);
    `CHK(m_valid, 1'b0)
  endtask
  task automatic t_cam();
    cam_mode = 1'b1;
    cam_find(8'h00, 1'b0, 16'hffff, 5'h00, 16'h0000, 5'h00);
    cam_wr(5'h03, 8'h5a, 8'h00, 1'b0, 1);
    cam_wr(5'h09, 8'h5a, 8'h00, 1'b0, 1);
    cam_find(8'h5a, 1'b0, 16'h0208, 5'h03, 16'h0000, 5'h00);
    cam_find(8'h77, 1'b0, 16'h0000, 5'h00, 16'h0000, 5'h00);
    cam_wr(5'h06, 8'hc0, 8'h0f, 1'b1, 2);
    cam_find(8'hc5, 1'b0, 16'h0040, 5'h06, 16'h0000, 5'h00);
    cam_mode = 1'b0;
    cam_wr(5'h14, 8'h3c, 8'h00, 1'b0, 1);
    cam_find(8'h3c, 1'b1, 16'h0000, 5'h00, 16'h0010, 5'h14);
  endtask
  // =====================================================
  // Main sequence and hang guard
  initial begin
    i_resetn = 1'b0;
    {in_ce, wr_ce, rd_ce} = 6'h3f;
    {clr, we, re, hold, slow} = 10'h000;
    for (int i = 0; i < 2; i++) begin
      waddr[i] = 12'h000;
      raddr[i] = 12'h000;
      wdata[i] = 16'h0000;
    end
    {cam_mode, cam_write, cam_dc, cam_look} = 4'h0;
    {cam_waddr, cam_wdata, cam_wcare, cam_key} = 29'h0;
    repeat (12) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    t_ram_basic(0);
    t_ram_basic(1);
    t_ram_ports();
    t_cam();
    print_verdict();
  end
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
